// ### rtl/oar_pkg.sv
// shared constants and types of the octal serial readout block
`default_nettype none
package oar_pkg;
    localparam int OAR_NCH        = 8;
    localparam int OAR_RES_W      = 13;
    localparam int OAR_CH_W       = 3;
    localparam int OAR_BIT_W      = 4;
    localparam int OAR_FIFO_DEPTH = 16;
    localparam logic [3:0] OAR_LAST_BIT = 4'hc;
    localparam logic [1:0] OAR_STRAP_SETTLE = 2'h3;
    // register map, byte offsets on axi4-lite
    localparam int OAR_ADDR_W = 4;
    localparam logic [3:0] OAR_REG_CTRL   = 4'h0;
    localparam logic [3:0] OAR_REG_STATUS = 4'h4;
    localparam logic [3:0] OAR_REG_FRAMES = 4'h8;
    // field positions
    localparam int OAR_CTRL_TEST  = 0;
    localparam int OAR_CTRL_CLR   = 1;
    localparam int OAR_ST_STD     = 0;
    localparam int OAR_ST_DDR     = 2;
    localparam int OAR_ST_ECHO    = 3;
    localparam int OAR_ST_REFBUF  = 4;
    localparam int OAR_ST_UNDER   = 8;
    localparam int OAR_ST_LEVEL   = 16;
    localparam logic [1:0] OAR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] OAR_RESP_SLVERR = 2'h2;
    // output standard and converter phase
    typedef enum logic [1:0] {OAR_STD_CMOS, OAR_STD_LVDS, OAR_STD_LVDS_LP} oar_std_t;
    typedef enum logic {OAR_ACQUIRE, OAR_CONVERT} oar_phase_t;
    // strap settings caught after reset
    typedef struct packed {
        logic io_level;
        logic io_float;
        logic ddr;
        logic echo_dis;
        logic refbuf;
    } oar_strap_t;
    // one simultaneous sample of all channels, two's complement each
    typedef logic [OAR_RES_W-1:0] oar_res_t;
    typedef struct packed {
        oar_res_t [OAR_NCH-1:0] ch;
    } oar_frame_t;
endpackage
`default_nettype wire

// ### rtl/oar_fifo.sv
// sample fifo with valid/ready on both sides
`default_nettype none
module oar_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    localparam int AW   = $clog2(DEPTH)
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output var  logic             out_valid,
    output var  logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    output var  logic [AW:0]      level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             full_r;
    logic             empty_r;
    wire              push = in_valid & ~full_r;
    wire              pop  = ~empty_r & out_ready;
    wire  [AW:0]      count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    wire  [AW-1:0]    wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
    wire  [AW-1:0]    rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;

    // flags are registered so that ready and valid come from flops
    assign in_ready  = ~full_r;
    assign out_valid = ~empty_r;
    assign out_data  = mem[rd_ptr_r];
    assign level     = count_r;

    // storage write
    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
            full_r   <= 1'b0;
            empty_r  <= 1'b1;
        end else begin
            if (push) wr_ptr_r <= wr_ptr_nxt;
            if (pop) rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            full_r  <= (count_nxt == (AW+1)'(DEPTH));
            empty_r <= (count_nxt == '0);
        end
    end
endmodule
`default_nettype wire

// ### rtl/oar_readout.sv
// conversion control and serial readout of the octal converter
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module oar_readout
    import oar_pkg::*;
#(
    parameter int NCH   = OAR_NCH,
    parameter int DEPTH = OAR_FIFO_DEPTH
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [OAR_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output var  logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output var  logic                  s_axi_wready,
    output var  logic [1:0]            s_axi_bresp,
    output var  logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [OAR_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output var  logic                  s_axi_arready,
    output var  logic [31:0]           s_axi_rdata,
    output var  logic [1:0]            s_axi_rresp,
    output var  logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  smp_valid,
    input  wire oar_frame_t            smp_data,
    output var  logic                  smp_ready,
    input  wire logic                  convert_strobe_n,
    input  wire logic                  shift_clock,
    input  wire logic                  io_mode_level,
    input  wire logic                  io_mode_floating,
    input  wire logic                  data_rate_ddr,
    input  wire logic                  echo_clock_disable,
    input  wire logic                  ref_buffer_on,
    output var  logic [NCH-1:0]        serial_out,
    output var  logic                  serial_oe,
    output var  logic [NCH/2-1:0]      lvds_pair,
    output var  logic                  lvds_low_power,
    output var  logic                  echoed_shift_clock,
    output var  logic                  ref_buffer_enable,
    output var  logic                  conversion_start
);
    localparam int LW = $clog2(DEPTH) + 1;

    // pin synchronisers: first stage feeds only the second
    logic       cnv_m_r, cnv_s_r, cnv_d_r;
    logic       sck_m_r, sck_s_r, sck_d_r;
    oar_strap_t strap_m_r, strap_s_r, strap_r;
    logic [1:0] settle_r;

    // readout state
    oar_phase_t             phase_r;
    oar_res_t [NCH-1:0]     frame_r;
    logic [OAR_BIT_W-1:0]   bit_r;
    logic [OAR_CH_W-1:0]    ofs_r;
    logic [NCH-1:0]         ser_r;
    logic [NCH/2-1:0]       lvds_r;
    logic                   oe_r, lp_r, echo_r, refbuf_r, start_r;

    // software state
    logic        test_r, under_r;
    logic [31:0] frames_r;

    // axi state
    logic                  awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic                  aw_hold_r, w_hold_r;
    logic [OAR_ADDR_W-1:0] awaddr_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic [1:0]            bresp_r, rresp_r;
    logic [31:0]           rdata_r;

    // fifo hookup
    logic            fifo_valid, fifo_in_ready, fifo_pop;
    oar_frame_t      fifo_data;
    logic [LW-1:0]   fifo_level;

    oar_fifo #(
        .WIDTH ($bits(oar_frame_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (smp_valid),
        .in_data   (smp_data),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop),
        .level     (fifo_level)
    );

    // edge detection on the second synchroniser stage
    wire cnv_fall = cnv_d_r & ~cnv_s_r;
    wire cnv_rise = ~cnv_d_r & cnv_s_r;
    wire sck_fall = sck_d_r & ~sck_s_r;
    wire sck_rise = ~sck_d_r & sck_s_r;

    // strap decode
    wire      strap_done = (settle_r == OAR_STRAP_SETTLE);
    wire      is_cmos    = ~strap_r.io_float & ~strap_r.io_level;
    oar_std_t std_sel;
    assign std_sel = strap_r.io_float ? OAR_STD_LVDS_LP :
                     (strap_r.io_level ? OAR_STD_LVDS : OAR_STD_CMOS);

    // shift advance: falling edge only, or both edges in double rate
    wire advance = (phase_r == OAR_CONVERT) &
                   (sck_fall | (strap_r.ddr & sck_rise));
    wire last_bit = (bit_r == OAR_LAST_BIT);  // 13 edges per result

    // conversion start takes one frame from the fifo or the test pattern
    assign fifo_pop = cnv_fall & ~test_r & fifo_valid;
    wire underrun = cnv_fall & ~test_r & ~fifo_valid;

    oar_res_t [NCH-1:0]   load_frame;
    logic     [NCH-1:0]   ch_bit;
    wire  [OAR_BIT_W-1:0] bit_sel = OAR_LAST_BIT - bit_r;  // msb first

    // per channel: load source and current serial bit
    for (genvar k = 0; k < NCH; k++) begin : g_ch
        wire [OAR_CH_W-1:0] src = OAR_CH_W'(k) + ofs_r;  // wraps seven to zero
        assign load_frame[k] = test_r ? OAR_RES_W'(k) :
                               (fifo_valid ? fifo_data.ch[k] : '0);  // kept two's complement
        assign ch_bit[k] = frame_r[src][bit_sel];  // own channel first
    end

    // axi write path decode
    wire aw_take     = s_axi_awvalid & awready_r;
    wire w_take      = s_axi_wvalid & wready_r;
    wire do_write    = aw_hold_r & w_hold_r & ~bvalid_r;
    wire aw_hold_nxt = (aw_hold_r | aw_take) & ~do_write;
    wire w_hold_nxt  = (w_hold_r | w_take) & ~do_write;
    wire bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready);
    wire wr_ctrl_hit = (awaddr_r[3:2] == OAR_REG_CTRL[3:2]);
    wire wr_mapped   = wr_ctrl_hit | (awaddr_r[3:2] == OAR_REG_STATUS[3:2]) |
                       (awaddr_r[3:2] == OAR_REG_FRAMES[3:2]);
    wire wr_ctrl     = do_write & wr_ctrl_hit & wstrb_r[0];
    wire clr_under   = wr_ctrl & wdata_r[OAR_CTRL_CLR];

    // axi read path decode
    wire ar_take    = s_axi_arvalid & arready_r;
    wire rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);
    wire rd_ctrl    = (s_axi_araddr[3:2] == OAR_REG_CTRL[3:2]);
    wire rd_status  = (s_axi_araddr[3:2] == OAR_REG_STATUS[3:2]);
    wire rd_frames  = (s_axi_araddr[3:2] == OAR_REG_FRAMES[3:2]);
    wire rd_hit     = rd_ctrl | rd_status | rd_frames;
    wire [31:0] ctrl_word   = 32'(test_r) << OAR_CTRL_TEST;
    wire [31:0] status_word = (32'(std_sel) << OAR_ST_STD) |
                              (32'(strap_r.ddr) << OAR_ST_DDR) |
                              (32'(strap_r.echo_dis) << OAR_ST_ECHO) |
                              (32'(strap_r.refbuf) << OAR_ST_REFBUF) |
                              (32'(under_r) << OAR_ST_UNDER) |
                              (32'(fifo_level) << OAR_ST_LEVEL);
    wire [31:0] rd_word = rd_ctrl ? ctrl_word :
                          (rd_status ? status_word :
                          (rd_frames ? frames_r : 32'h0000_0000));

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign smp_ready     = fifo_in_ready;

    assign serial_out         = ser_r;
    assign serial_oe          = oe_r;
    assign lvds_pair          = lvds_r;
    assign lvds_low_power     = lp_r;
    assign echoed_shift_clock = echo_r;
    assign ref_buffer_enable  = refbuf_r;
    assign conversion_start   = start_r;

    // pin synchronisers and edge history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnv_m_r   <= 1'b1;
            cnv_s_r   <= 1'b1;
            cnv_d_r   <= 1'b1;
            sck_m_r   <= 1'b0;
            sck_s_r   <= 1'b0;
            sck_d_r   <= 1'b0;
            strap_m_r <= '0;
            strap_s_r <= '0;
        end else begin
            cnv_m_r   <= convert_strobe_n;
            cnv_s_r   <= cnv_m_r;
            cnv_d_r   <= cnv_s_r;
            sck_m_r   <= shift_clock;
            sck_s_r   <= sck_m_r;
            sck_d_r   <= sck_s_r;
            strap_m_r <= '{io_mode_level, io_mode_floating, data_rate_ddr,
                           echo_clock_disable, ref_buffer_on};
            strap_s_r <= strap_m_r;
        end
    end

    // straps are caught once the synchroniser has filled after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r <= '0;
            strap_r  <= '0;
        end else if (!strap_done) begin
            settle_r <= settle_r + 1'b1;
            strap_r  <= strap_s_r;
        end
    end

    // phase machine; identical for every output standard
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= OAR_ACQUIRE;
        end else begin
            unique case (phase_r)
                OAR_ACQUIRE: begin
                    if (cnv_fall && strap_done) phase_r <= OAR_CONVERT;
                end
                OAR_CONVERT: begin
                    if (cnv_rise) phase_r <= OAR_ACQUIRE;  // high level is acquisition
                end
            endcase
        end
    end

    // result frame capture at conversion start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_r <= '0;
        end else if (cnv_fall) begin
            frame_r <= load_frame;  // all channels at once
        end
    end

    // bit and channel position of the shift sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bit_r <= '0;
            ofs_r <= '0;
        end else if (cnv_fall) begin
            bit_r <= '0;
            ofs_r <= '0;
        end else if (advance) begin
            bit_r <= last_bit ? '0 : bit_r + 1'b1;
            ofs_r <= last_bit ? ofs_r + 1'b1 : ofs_r;  // next channel ascending
        end
    end

    // serial outputs: cmos on each channel pin, lvds pairs carry two channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ser_r  <= '0;
            lvds_r <= '0;
            oe_r   <= 1'b0;
            lp_r   <= 1'b0;
        end else begin
            oe_r <= (phase_r == OAR_CONVERT) & is_cmos;  // released in acquisition
            lp_r <= (std_sel == OAR_STD_LVDS_LP);
            for (int p = 0; p < NCH / 2; p++) begin
                lvds_r[p] <= (phase_r == OAR_CONVERT) & ~is_cmos & ch_bit[2*p];
            end
            ser_r <= ((phase_r == OAR_CONVERT) && is_cmos) ? ch_bit : '0;
        end
    end

    // echoed clock, buffer enable and start pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            echo_r   <= 1'b0;
            refbuf_r <= 1'b0;
            start_r  <= 1'b0;
        end else begin
            echo_r   <= sck_s_r & ~strap_r.echo_dis;  // delayed copy
            refbuf_r <= strap_r.refbuf;
            start_r  <= cnv_fall & strap_done;
        end
    end

    // control, underrun flag (set beats clear) and frame counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            test_r   <= 1'b0;
            under_r  <= 1'b0;
            frames_r <= '0;
        end else begin
            if (wr_ctrl) test_r <= wdata_r[OAR_CTRL_TEST];
            under_r <= underrun | (under_r & ~clr_under);
            if (cnv_fall && strap_done) frames_r <= frames_r + 1'b1;
        end
    end

    // axi write channel handshakes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= OAR_RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            bvalid_r  <= bvalid_nxt;
            awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
            wready_r  <= ~w_hold_nxt & ~bvalid_nxt;
            if (do_write) bresp_r <= wr_mapped ? OAR_RESP_OKAY : OAR_RESP_SLVERR;
        end
    end

    // axi write payload capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else begin
            if (aw_take) awaddr_r <= s_axi_awaddr;
            if (w_take) wdata_r <= s_axi_wdata;
            if (w_take) wstrb_r <= s_axi_wstrb;
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= '0;
            rresp_r   <= OAR_RESP_OKAY;
        end else begin
            rvalid_r  <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_word;
                rresp_r <= rd_hit ? OAR_RESP_OKAY : OAR_RESP_SLVERR;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/oar_readout_monitor.sv
// pin-level assertions for the octal serial readout block
`default_nettype none
module oar_readout_monitor #(
    parameter int NCH = 8
) (
    input wire logic           aclk,
    input wire logic           aresetn,
    input wire logic           convert_strobe_n,
    input wire logic           shift_clock,
    input wire logic           io_mode_level,
    input wire logic           io_mode_floating,
    input wire logic           data_rate_ddr,
    input wire logic           echo_clock_disable,
    input wire logic           ref_buffer_on,
    input wire logic [NCH-1:0] serial_out,
    input wire logic           serial_oe,
    input wire logic           lvds_low_power,
    input wire logic           echoed_shift_clock,
    input wire logic           ref_buffer_enable,
    input wire logic           conversion_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // strobe fall starts a conversion, one pulse each
    AST_START: assert property ($fell(convert_strobe_n) |-> ##[1:6] conversion_start)
        else $error("no start pulse after strobe fall");
    AST_START_ONE: assert property (conversion_start |=> !conversion_start)
        else $error("start pulse longer than one cycle");
    // strobe high means acquisition, nothing shifted out
    AST_ACQ_QUIET: assert property (convert_strobe_n [*6] |-> serial_out == '0 && !serial_oe)
        else $error("data driven during acquisition");
    AST_CMOS_OE: assert property ((!io_mode_level && !io_mode_floating && !convert_strobe_n) [*6]
        |-> serial_oe)
        else $error("cmos outputs not driven in conversion");
    AST_LVDS_QUIET: assert property ((io_mode_level || io_mode_floating) |-> serial_out == '0 && !serial_oe)
        else $error("cmos outputs active in lvds mode");
    AST_LOW_POWER: assert property (io_mode_floating [*8] |-> lvds_low_power)
        else $error("floating strap without low-power lvds");
    // echoed clock follows the shift clock a few cycles later
    AST_ECHO_HIGH: assert property (!echo_clock_disable && $rose(shift_clock)
        |-> ##[2:5] echoed_shift_clock)
        else $error("echoed clock did not rise");
    AST_ECHO_LOW: assert property ($fell(shift_clock) |-> ##[2:5] !echoed_shift_clock)
        else $error("echoed clock did not fall");
    AST_ECHO_OFF: assert property (echo_clock_disable [*8] |-> !echoed_shift_clock)
        else $error("echoed clock active while disabled");
    AST_REFBUF_ON: assert property (ref_buffer_on [*8] |-> ref_buffer_enable)
        else $error("reference buffers off with strap high");
    AST_REFBUF_OFF: assert property (!ref_buffer_on [*8] |-> !ref_buffer_enable)
        else $error("reference buffers on with strap low");
    // single rate: a rising shift edge moves no data
    AST_SDR_HOLD: assert property (!data_rate_ddr && $rose(shift_clock) |-> ##3 $stable(serial_out) [*4])
        else $error("data moved on rising edge in single rate");
endmodule
`default_nettype wire

// ### testbench/oar_host_model.sv
// host side model: drives strobe and shift clock, catches the serial bits
`default_nettype none
module oar_host_model (
    output logic             strobe_n,
    output logic             shift_clk,
    input  wire logic [7:0]  sdata,
    output logic             cap_stb,
    output logic [7:0]       cap
);
    timeunit 1ns;
    timeprecision 1ps;
    // shift clock stands still low between frames
    initial begin
        strobe_n = 1'b1;
        shift_clk = 1'b0;
        cap_stb = 1'b0;
        cap = 8'h00;
    end
    // one frame: a bit is caught 30 ns after the edge that will replace it in double rate, 30 ns after the rise in single rate
    task automatic frame(input int n, input bit ddr);
        #5 strobe_n = 1'b0;
        #200;
        for (int j = 0; j < n; j++) begin
            shift_clk = ddr ? ~shift_clk : 1'b1;
            #30 cap = sdata;
            cap_stb = 1'b1;
            #50 cap_stb = 1'b0;
            if (!ddr) shift_clk = 1'b0;
            if (!ddr) #80;
        end
        #200;
        strobe_n = 1'b1;
        #395;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the octal serial readout block
`default_nettype none
module tb_top import oar_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, smp_valid, lvl, flt, ddr, edis, rbuf, lv;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata;
    oar_frame_t  smp_data;
    wire         awready, wready, bvalid, arready, rvalid, smp_ready, strobe_n, shift_clk, cap_stb;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  sout, cap, hin;
    wire  [3:0]  pair;
    int          n_fail, compares;
    logic [33:0] exp_rd[$];
    logic [7:0]  exp_bit[$];
    oar_frame_t  frm_q[$];
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    oar_readout u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .smp_valid(smp_valid),
        .smp_data(smp_data), .smp_ready(smp_ready), .convert_strobe_n(strobe_n), .shift_clock(shift_clk),
        .io_mode_level(lvl), .io_mode_floating(flt), .data_rate_ddr(ddr), .echo_clock_disable(edis),
        .ref_buffer_on(rbuf), .serial_out(sout), .serial_oe(), .lvds_pair(pair), .lvds_low_power(),
        .echoed_shift_clock(), .ref_buffer_enable(), .conversion_start());
    // host watches the pairs in lvds modes, the cmos lines otherwise
    assign hin = lv ? {4'h0, pair} : sout;
    oar_host_model u_host (.strobe_n(strobe_n), .shift_clk(shift_clk), .sdata(hin), .cap_stb(cap_stb), .cap(cap));
    task automatic cmp_reg(input logic [33:0] g, input logic [33:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_bits(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tmo(input int i);
        if (i >= 100) begin
            n_fail++;
            $display("timeout at %0t", $time);
            close_out();
        end
    endtask
    // result watchers: oldest note against each answer that appears
    always @(posedge aclk) begin
        if (rvalid && rready) cmp_reg({rresp, rdata}, exp_rd.pop_front());
        else if (bvalid && bready) cmp_reg({bresp, 32'h0}, exp_rd.pop_front());
    end
    always @(posedge cap_stb) cmp_bits(cap, exp_bit.pop_front());
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        int i;
        @(posedge aclk);
        exp_rd.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(i);
    endtask
    task automatic axr(input logic [3:0] a, input logic [33:0] e);
        int i;
        @(posedge aclk);
        exp_rd.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        tmo(i);
    endtask
    function automatic logic [31:0] st(input int s, d, e, b, u, l);
        return (32'(l) << OAR_ST_LEVEL) | (32'(u) << OAR_ST_UNDER) | (32'(b) << OAR_ST_REFBUF)
            | (32'(e) << OAR_ST_ECHO) | (32'(d) << OAR_ST_DDR) | 32'(s);
    endfunction
    function automatic oar_frame_t rnd_fr();
        oar_frame_t f;
        for (int k = 0; k < OAR_NCH; k++) f.ch[k] = 13'($urandom);
        return f;
    endfunction
    // reset with a new strap setting, held 8 cycles
    task automatic cfg(input logic l, f, d, e, r);
        @(posedge aclk);
        aresetn <= 1'b0;
        lvl <= l;
        flt <= f;
        ddr <= d;
        edis <= e;
        rbuf <= r;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (10) @(posedge aclk);
        frm_q.delete();
    endtask
    // offer random samples for c cycles, noting those taken
    task automatic offer(input int c);
        oar_frame_t f;
        f = rnd_fr();
        smp_valid <= 1'b1;
        smp_data <= f;
        repeat (c) begin
            @(posedge aclk);
            if (smp_ready) begin
                frm_q.push_back(f);
                f = rnd_fr();
                smp_data <= f;
            end
        end
        smp_valid <= 1'b0;
    endtask
    // src 0 fifo sample, 1 test pattern, 2 underrun zeros
    task automatic run(input int n, input bit dd, input int src);
        oar_frame_t f;
        logic [7:0] b;
        f = '0;
        if (src == 0) f = frm_q.pop_front();
        if (src == 1) for (int k = 0; k < OAR_NCH; k++) f.ch[k] = 13'(k);
        for (int j = 0; j < n; j++) begin
            for (int k = 0; k < 8; k++) b[k] = (lv && k > 3) ? 1'b0 : f.ch[((lv ? 2*k : k) + j/13) % 8][12 - j%13];
            exp_bit.push_back(b);
        end
        u_host.frame(n, dd);
    endtask
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, smp_valid, lv} = 8'h00;
        {lvl, flt, ddr, edis, rbuf} = 5'h01;
        {awaddr, araddr, wdata, smp_data} = '0;
        wstrb = 4'hf;
        void'($urandom(32'hf67a));
        cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        offer(40);
        cmp_reg(34'(smp_ready), 34'h0);
        cmp_reg(34'(frm_q.size()), 34'd16);
        axr(OAR_REG_STATUS, {OAR_RESP_OKAY, st(0, 0, 0, 1, 0, 16)});
        run(26, 1'b0, 0);
        run(104, 1'b0, 0);
        repeat (14) run(2, 1'b0, 0);
        axr(OAR_REG_FRAMES, {OAR_RESP_OKAY, 32'd16});
        run(13, 1'b0, 2);
        axr(OAR_REG_STATUS, {OAR_RESP_OKAY, st(0, 0, 0, 1, 1, 0)});
        axw(OAR_REG_CTRL, 32'h3, OAR_RESP_OKAY);
        axr(OAR_REG_CTRL, {OAR_RESP_OKAY, 32'h1});
        run(13, 1'b0, 1);
        axr(OAR_REG_STATUS, {OAR_RESP_OKAY, st(0, 0, 0, 1, 0, 0)});
        axw(4'hc, 32'h1, OAR_RESP_SLVERR);
        axr(4'hc, {OAR_RESP_SLVERR, 32'h0});
        // cmos double rate, then both lvds standards
        for (int m = 0; m < 3; m++) begin
            cfg(m == 1, m == 2, m != 1, m == 0, m != 0);
            lv = (m != 0);
            offer(2);
            axr(OAR_REG_STATUS, {OAR_RESP_OKAY, st(m, m != 1, m == 0, m != 0, 0, 2)});
            run(26, m != 1, 0);
            run(26, m != 1, 0);
        end
        close_out();
    end
endmodule
bind oar_readout oar_readout_monitor #(.NCH(NCH)) u_mon (.aclk(aclk), .aresetn(aresetn),
    .convert_strobe_n(convert_strobe_n), .shift_clock(shift_clock), .io_mode_level(io_mode_level),
    .io_mode_floating(io_mode_floating), .data_rate_ddr(data_rate_ddr), .echo_clock_disable(echo_clock_disable),
    .ref_buffer_on(ref_buffer_on), .serial_out(serial_out), .serial_oe(serial_oe), .lvds_low_power(lvds_low_power),
    .echoed_shift_clock(echoed_shift_clock), .ref_buffer_enable(ref_buffer_enable),
    .conversion_start(conversion_start));
`default_nettype wire
